// >>> bench/rbt_bus_far.sv
// far-side model of one shared data bus
`timescale 1ns/1ps
`default_nettype none
`include "rbt_cfg.svh"
module rbt_bus_far (
  // clock
  input wire logic mclk,
  // device drive
  input wire logic [`RBT_DATA_W-1:0] devOut,
  input wire logic [`RBT_DATA_W-1:0] devOe,
  // far drive
  input wire logic [`RBT_DATA_W-1:0] farData,
  input wire logic [`RBT_DATA_W-1:0] farOe,
  // resolved level
  output logic [`RBT_DATA_W-1:0] busLvl
);
  logic [`RBT_DATA_W-1:0] lastLvl;
  always_ff @(posedge mclk) begin
    lastLvl <= busLvl;
  end
  // each bit on its own; a released bit shows the inverse of its last level
  always_comb begin
    for (int i = 0; i < `RBT_DATA_W; i++) begin
      busLvl[i] = farOe[i] ? farData[i] : (devOe[i] ? devOut[i] : ~lastLvl[i]);
    end
  end
endmodule
`default_nettype wire

// >>> bench/rbt_transceiver_asserts.sv
// port assertions of the registered bus transceiver
`timescale 1ns/1ps
`default_nettype none
`include "rbt_cfg.svh"
module rbt_transceiver_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // direction controls
  input wire logic [`RBT_HALVES-1:0] aToBClock,
  input wire logic [`RBT_HALVES-1:0] aToBClockEnableN,
  input wire logic [`RBT_HALVES-1:0] aToBOutputEnableN,
  input wire logic [`RBT_HALVES-1:0] bToAClock,
  input wire logic [`RBT_HALVES-1:0] bToAClockEnableN,
  input wire logic [`RBT_HALVES-1:0] bToAOutputEnableN,
  // bus pins
  input wire logic [`RBT_DATA_W-1:0] aIn,
  input wire logic [`RBT_DATA_W-1:0] aOut,
  input wire logic [`RBT_DATA_W-1:0] aOe,
  input wire logic [`RBT_DATA_W-1:0] bIn,
  input wire logic [`RBT_DATA_W-1:0] bOut,
  input wire logic [`RBT_DATA_W-1:0] bOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence sQuiet(c, en);
    (en || $stable(c)) [*8];
  endsequence
  sequence sCapEdge(c, en, d);
    $rose(c) && !en && $stable(d);
  endsequence
  property pOe(logic n, logic [7:0] oe);
    $stable(n) [*6] |-> oe == {8{!n}};
  endproperty
  property pHold(logic c, logic en, logic [7:0] o);
    sQuiet(c, en) |-> $stable(o);
  endproperty
  property pCap(logic c, logic en, logic [7:0] d, logic [7:0] o);
    sCapEdge(c, en, d) |-> ##6 o == $past(d, 6);
  endproperty
  chk_oe_ab_lo: assert property (pOe(aToBOutputEnableN[0], bOe[7:0]))
    else $error("bus b drive enable wrong in low half");
  chk_oe_ab_hi: assert property (pOe(aToBOutputEnableN[1], bOe[15:8]))
    else $error("bus b drive enable wrong in high half");
  chk_oe_ba_lo: assert property (pOe(bToAOutputEnableN[0], aOe[7:0]))
    else $error("bus a drive enable wrong in low half");
  chk_hold_ab_lo: assert property (
    pHold(aToBClock[0], aToBClockEnableN[0], bOut[7:0]))
    else $error("b side value moved without capture");
  chk_hold_ba_hi: assert property (
    pHold(bToAClock[1], bToAClockEnableN[1], aOut[15:8]))
    else $error("a side value moved without capture");
  chk_cap_ab_lo: assert property (
    pCap(aToBClock[0], aToBClockEnableN[0], aIn[7:0], bOut[7:0]))
    else $error("low half a to b capture lost");
  chk_cap_ab_hi: assert property (
    pCap(aToBClock[1], aToBClockEnableN[1], aIn[15:8], bOut[15:8]))
    else $error("high half a to b capture lost");
  chk_cap_ba_lo: assert property (
    pCap(bToAClock[0], bToAClockEnableN[0], bIn[7:0], aOut[7:0]))
    else $error("low half b to a capture lost");
endmodule
`default_nettype wire

// >>> bench/rbt_transceiver_tb.sv
// self-checking bench of the registered bus transceiver
`timescale 1ns/1ps
`default_nettype none
`include "rbt_cfg.svh"
module rbt_transceiver_tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] ckAB = 2'h0, enAB = 2'h3, a_to_b_output_enable_n = 2'h3, ckBA = 2'h0, enBA = 2'h3, b_to_a_output_enable_n = 2'h3;
  logic [15:0] farA = 16'h0000, farB = 16'h0000, farAOe = 16'hFFFF, farBOe = 16'hFFFF;
  logic [15:0] aIn, aOut, aOe, bIn, bOut, bOe;
  logic [1:0] stall;
  int errors = 0, total_checks = 0, cyc = 0;
  always #10 mclk = ~mclk;
  rbt_transceiver i_rbt_transceiver (.mclk(mclk), .rst_b(rst_b), .aToBClock(ckAB),
    .aToBClockEnableN(enAB), .aToBOutputEnableN(a_to_b_output_enable_n), .bToAClock(ckBA),
    .bToAClockEnableN(enBA), .bToAOutputEnableN(b_to_a_output_enable_n), .aIn(aIn), .aOut(aOut),
    .aOe(aOe), .bIn(bIn), .bOut(bOut), .bOe(bOe), .captureStall(stall));
  rbt_bus_far i_rbt_bus_far_a (.mclk(mclk), .devOut(aOut), .devOe(aOe), .farData(farA),
    .farOe(farAOe), .busLvl(aIn));
  rbt_bus_far i_rbt_bus_far_b (.mclk(mclk), .devOut(bOut), .devOe(bOe), .farData(farB),
    .farOe(farBOe), .busLvl(bIn));
  task step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task chk(input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task pulse(input logic [1:0] ab, input logic [1:0] ba);
    step(4);
    ckAB = ab;
    ckBA = ba;
    step(5);
    ckAB = 2'h0;
    ckBA = 2'h0;
    step(10);
  endtask
  task test_done;
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task t_ab;
    chk(16'h0000, bOe);
    farA = 16'hA55A;
    farBOe = 16'h0000;
    enAB = 2'h0;
    a_to_b_output_enable_n = 2'h0;
    pulse(2'h3, 2'h0);
    chk(16'hFFFF, bOe);
    chk(16'hA55A, bOut);
    chk(16'hA55A, bIn);
    chk(16'h0000, aOe);
    chk(16'h0000, {14'h0000, stall});
  endtask
  task t_gate;
    farA = 16'h1234;
    enAB = 2'h3;
    pulse(2'h3, 2'h0);
    chk(16'hA55A, bOut);
    enAB = 2'h1;
    pulse(2'h3, 2'h0);
    chk(16'h125A, bOut);
    step(30);
    chk(16'h125A, bIn);
  endtask
  task t_ba;
    a_to_b_output_enable_n = 2'h3;
    step(8);
    chk(16'h0000, bOe);
    farB = 16'hC3F0;
    farBOe = 16'hFFFF;
    farAOe = 16'h0000;
    enBA = 2'h0;
    b_to_a_output_enable_n = 2'h2;
    pulse(2'h0, 2'h3);
    chk(16'h00FF, aOe);
    chk(16'hC3F0, aOut);
    chk(16'h00F0, {8'h00, aIn[7:0]});
    chk(16'h125A, bOut);
  endtask
  task t_rst;
    rst_b = 1'b0;
    step(2);
    chk(16'h0000, aOut);
    chk(16'h0000, aOe);
    rst_b = 1'b1;
    step(8);
    chk(16'h00FF, aOe);
    chk(16'h0000, aOut);
    chk(16'h0000, {14'h0000, stall});
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 3000) begin
      errors++;
      test_done;
    end
  end
  initial begin
    step(2);
    rst_b = 1'b1;
    step(4);
    t_ab;
    t_gate;
    t_ba;
    t_rst;
    test_done;
  end
endmodule
bind rbt_transceiver rbt_transceiver_asserts i_rbt_transceiver_asserts (.mclk, .rst_b,
  .aToBClock, .aToBClockEnableN, .aToBOutputEnableN, .bToAClock, .bToAClockEnableN,
  .bToAOutputEnableN, .aIn, .aOut, .aOe, .bIn, .bOut, .bOe);
`default_nettype wire

// >>> design/rbt_fifo.sv
// word fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module rbt_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] wrPtr_next;
  logic [AW-1:0] rdPtr_reg;
  logic [AW-1:0] rdPtr_next;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic inFire;
  logic outFire;

  assign inReady = (count_reg != (AW + 1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign inFire = inValid && inReady;
  assign outFire = outValid && outReady;

  function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      ptrInc = '0;
    end else begin
      ptrInc = p + AW'(1);
    end
  endfunction

  always_comb begin
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    count_next = count_reg;
    if (inFire) begin
      wrPtr_next = ptrInc(wrPtr_reg);
    end
    if (outFire) begin
      rdPtr_next = ptrInc(rdPtr_reg);
    end
    if (inFire && !outFire) begin
      count_next = count_reg + (AW + 1)'(1);
    end else if (outFire && !inFire) begin
      count_next = count_reg - (AW + 1)'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge mclk) begin
    if (inFire) begin
      mem[wrPtr_reg] <= inData;
    end
  end

endmodule

`default_nettype wire

// >>> design/rbt_transceiver.sv
// 16-bit registered bus transceiver, two directions, two halves
//
// Overview of operation
// - two storage banks, A-to-B and B-to-A
// - capture source bus on rising direction clock
// - capture only while clock enable low
// - otherwise bank keeps last captured value
// - output enable low drives bank onto bus
// - B-to-A path has own clock, enables
// - two 8-bit halves, each fully separate controls
`timescale 1ns/1ps
`default_nettype none
`include "rbt_cfg.svh"

module rbt_transceiver (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // a-to-b controls, one bit per half
  input wire logic [`RBT_HALVES-1:0] aToBClock,
  input wire logic [`RBT_HALVES-1:0] aToBClockEnableN,
  input wire logic [`RBT_HALVES-1:0] aToBOutputEnableN,
  // b-to-a controls, one bit per half
  input wire logic [`RBT_HALVES-1:0] bToAClock,
  input wire logic [`RBT_HALVES-1:0] bToAClockEnableN,
  input wire logic [`RBT_HALVES-1:0] bToAOutputEnableN,
  // bus a pins
  input wire logic [`RBT_DATA_W-1:0] aIn,
  output logic [`RBT_DATA_W-1:0] aOut,
  output logic [`RBT_DATA_W-1:0] aOe,
  // bus b pins
  input wire logic [`RBT_DATA_W-1:0] bIn,
  output logic [`RBT_DATA_W-1:0] bOut,
  output logic [`RBT_DATA_W-1:0] bOe,
  // capture path stalled, a capture is waiting for the fifo
  output logic [`RBT_DIRS-1:0] captureStall
);

  localparam int WORD_W = $bits(rbt_pkg::rbt_word_t);

  // control and data synchronisers
  rbt_pkg::rbt_ctrl_t [`RBT_DIRS-1:0][`RBT_HALVES-1:0] ctrlPin;
  rbt_pkg::rbt_ctrl_t [`RBT_DIRS-1:0][`RBT_HALVES-1:0] ctrlS1_reg;
  rbt_pkg::rbt_ctrl_t [`RBT_DIRS-1:0][`RBT_HALVES-1:0] ctrlS2_reg;
  rbt_pkg::rbt_ctrl_t [`RBT_DIRS-1:0][`RBT_HALVES-1:0] ctrlS3_reg;
  rbt_pkg::rbt_ctrl_t [`RBT_DIRS-1:0][`RBT_HALVES-1:0] ctrlLvl_reg;
  rbt_pkg::rbt_ctrl_t [`RBT_DIRS-1:0][`RBT_HALVES-1:0] ctrlLvl_next;
  logic [`RBT_DIRS-1:0][`RBT_DATA_W-1:0] dataPin;
  logic [`RBT_DIRS-1:0][`RBT_DATA_W-1:0] dataS1_reg;
  logic [`RBT_DIRS-1:0][`RBT_DATA_W-1:0] dataS2_reg;
  logic [`RBT_DIRS-1:0][`RBT_DATA_W-1:0] dataS3_reg;

  // capture requests waiting for the fifo
  logic [`RBT_DIRS-1:0][`RBT_HALVES-1:0] capMask;
  logic [`RBT_DIRS-1:0] pendValid_reg;
  logic [`RBT_DIRS-1:0] pendValid_next;
  rbt_pkg::rbt_word_t [`RBT_DIRS-1:0] pendWord_reg;
  rbt_pkg::rbt_word_t [`RBT_DIRS-1:0] pendWord_next;

  // fifo draining side and register banks
  logic [`RBT_DIRS-1:0] fifoInReady;
  logic [`RBT_DIRS-1:0] fifoOutValid;
  logic [`RBT_DIRS-1:0][WORD_W-1:0] fifoOutData;
  logic drainReady_reg;
  logic drainReady_next;
  logic [`RBT_DIRS-1:0][`RBT_DATA_W-1:0] bank_reg;
  logic [`RBT_DIRS-1:0][`RBT_DATA_W-1:0] bank_next;
  logic [`RBT_DIRS-1:0][`RBT_DATA_W-1:0] oe_reg;
  logic [`RBT_DIRS-1:0][`RBT_DATA_W-1:0] oe_next;
  logic [`RBT_DIRS-1:0] stall_reg;
  logic [`RBT_DIRS-1:0] stall_next;

  // a level counts once the second and third stages agree
  function automatic logic [2:0] agreed(
    input logic [2:0] lvl,
    input logic [2:0] s2,
    input logic [2:0] s3
  );
    agreed = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & lvl);
  endfunction

  // gather the pins into per-direction, per-half groups
  always_comb begin
    for (int h = 0; h < `RBT_HALVES; h++) begin
      ctrlPin[`RBT_DIR_AB][h] = '{clk: aToBClock[h], enN: aToBClockEnableN[h],
                                  oeN: aToBOutputEnableN[h]};
      ctrlPin[`RBT_DIR_BA][h] = '{clk: bToAClock[h], enN: bToAClockEnableN[h],
                                  oeN: bToAOutputEnableN[h]};
    end
    dataPin[`RBT_DIR_AB] = aIn;
    dataPin[`RBT_DIR_BA] = bIn;
  end

  // three-stage synchronisers for pins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlS1_reg <= {(`RBT_DIRS * `RBT_HALVES){`RBT_CTRL_RST}};
      ctrlS2_reg <= {(`RBT_DIRS * `RBT_HALVES){`RBT_CTRL_RST}};
      ctrlS3_reg <= {(`RBT_DIRS * `RBT_HALVES){`RBT_CTRL_RST}};
      dataS1_reg <= '0;
      dataS2_reg <= '0;
      dataS3_reg <= '0;
    end else begin
      ctrlS1_reg <= ctrlPin;
      ctrlS2_reg <= ctrlS1_reg;
      ctrlS3_reg <= ctrlS2_reg;
      dataS1_reg <= dataPin;
      dataS2_reg <= dataS1_reg;
      dataS3_reg <= dataS2_reg;
    end
  end

  // filtered levels and capture decision per direction and half
  always_comb begin
    for (int d = 0; d < `RBT_DIRS; d++) begin
      for (int h = 0; h < `RBT_HALVES; h++) begin
        ctrlLvl_next[d][h] = agreed(ctrlLvl_reg[d][h], ctrlS2_reg[d][h],
                                    ctrlS3_reg[d][h]);
        capMask[d][h] = ctrlLvl_next[d][h].clk && !ctrlLvl_reg[d][h].clk
                        && !ctrlLvl_next[d][h].enN;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlLvl_reg <= {(`RBT_DIRS * `RBT_HALVES){`RBT_CTRL_RST}};
    end else begin
      ctrlLvl_reg <= ctrlLvl_next;
    end
  end

  // pending capture: held until the fifo takes it, later captures merge in
  always_comb begin
    for (int d = 0; d < `RBT_DIRS; d++) begin
      pendValid_next[d] = pendValid_reg[d] && !fifoInReady[d];
      pendWord_next[d] = pendWord_reg[d];
      if (!pendValid_next[d]) begin
        pendWord_next[d].halfMask = '0;
      end
      for (int h = 0; h < `RBT_HALVES; h++) begin
        if (capMask[d][h]) begin
          pendValid_next[d] = 1'b1;
          pendWord_next[d].halfMask[h] = 1'b1;
          pendWord_next[d].data[h*`RBT_HALF_W +: `RBT_HALF_W] =
            dataS3_reg[d][h*`RBT_HALF_W +: `RBT_HALF_W];
        end
      end
      stall_next[d] = pendValid_next[d] && pendValid_reg[d] && !fifoInReady[d];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pendValid_reg <= '0;
      pendWord_reg <= '0;
      stall_reg <= '0;
    end else begin
      pendValid_reg <= pendValid_next;
      pendWord_reg <= pendWord_next;
      stall_reg <= stall_next;
    end
  end

  // one fifo per direction between capture and bank
  for (genvar g = 0; g < `RBT_DIRS; g++) begin : gFifo
    rbt_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(`RBT_FIFO_DEPTH)
    ) uFifo (
      .mclk(mclk),
      .rst_b(rst_b),
      .inValid(pendValid_reg[g]),
      .inReady(fifoInReady[g]),
      .inData(pendWord_reg[g]),
      .outValid(fifoOutValid[g]),
      .outReady(drainReady_reg),
      .outData(fifoOutData[g])
    );
  end

  // register banks and output enables
  always_comb begin
    rbt_pkg::rbt_word_t w;
    w = '0;
    drainReady_next = 1'b1;
    bank_next = bank_reg;
    for (int d = 0; d < `RBT_DIRS; d++) begin
      w = rbt_pkg::rbt_word_t'(fifoOutData[d]);
      for (int h = 0; h < `RBT_HALVES; h++) begin
        if (fifoOutValid[d] && drainReady_reg && w.halfMask[h]) begin
          bank_next[d][h*`RBT_HALF_W +: `RBT_HALF_W] =
            w.data[h*`RBT_HALF_W +: `RBT_HALF_W];
        end
        oe_next[d][h*`RBT_HALF_W +: `RBT_HALF_W] =
          {`RBT_HALF_W{!ctrlLvl_reg[d][h].oeN}};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      drainReady_reg <= 1'b0;
      bank_reg <= {`RBT_DIRS{`RBT_BANK_RST}};
      oe_reg <= '0;
    end else begin
      drainReady_reg <= drainReady_next;
      bank_reg <= bank_next;
      oe_reg <= oe_next;
    end
  end

  // bank a-to-b drives bus b, bank b-to-a drives bus a, uninverted
  assign bOut = bank_reg[`RBT_DIR_AB];
  assign bOe = oe_reg[`RBT_DIR_AB];
  assign aOut = bank_reg[`RBT_DIR_BA];
  assign aOe = oe_reg[`RBT_DIR_BA];
  assign captureStall = stall_reg;

endmodule

`default_nettype wire

// >>> pkg/rbt_cfg.svh
// constants of the registered bus transceiver
`ifndef RBT_CFG_SVH
`define RBT_CFG_SVH

`define RBT_DATA_W 16
`define RBT_HALF_W 8
`define RBT_HALVES 2
`define RBT_DIRS 2
`define RBT_DIR_AB 0
`define RBT_DIR_BA 1
`define RBT_FIFO_DEPTH 16
`define RBT_BANK_RST 16'h0000
`define RBT_CTRL_RST 3'h7

`endif

// >>> pkg/rbt_pkg.sv
// types of the registered bus transceiver
`include "rbt_cfg.svh"

package rbt_pkg;

  // control pins of one direction of one half
  typedef struct packed {
    logic clk;
    logic enN;
    logic oeN;
  } rbt_ctrl_t;

  // one capture on its way to a register bank
  typedef struct packed {
    logic [`RBT_HALVES-1:0] halfMask;
    logic [`RBT_DATA_W-1:0] data;
  } rbt_word_t;

endpackage
